// ### logic/timer_prescale_pkg.sv
// constants and types shared by the timer prescaler and its pin synchroniser
// assumes a single 40 MHz system clock domain
package timer_prescale_pkg;

  localparam int MCLK_PERIOD_NS = 25;

  // byte offsets on the register bus
  localparam logic [3:0] GTC_OFFSET = 4'h0;
  localparam logic [3:0] CSEL_OFFSET = 4'h4;
  localparam logic [3:0] STATUS_OFFSET = 4'h8;

  // general_timer_control field positions and reset value
  localparam int HOLD_BIT = 7;
  localparam int CAPSEL_BIT = 6;
  localparam int PSR_BIT = 0;
  localparam logic [7:0] GTC_RESET = 8'h00;

  // clock select register: one 3-bit field per timer
  localparam int CSEL_T0_LSB = 0;
  localparam int CSEL_T1_LSB = 4;
  localparam logic [2:0] CSEL_RESET = 3'h0;

  // divider: 10 bits reach the /1024 tap
  localparam int DIV_WIDTH = 10;
  localparam logic [DIV_WIDTH-1:0] DIV_RESET = 10'h000;
  localparam int TAP8_BITS = 3;
  localparam int TAP64_BITS = 6;
  localparam int TAP256_BITS = 8;
  localparam int TAP1024_BITS = 10;

  localparam int NUM_TIMERS = 2;

  typedef enum logic [2:0] {
    CS_STOP,
    CS_DIRECT,
    CS_DIV8,
    CS_DIV64,
    CS_DIV256,
    CS_DIV1024,
    CS_EXT_FALL,
    CS_EXT_RISE
  } clock_select_type;

  typedef struct packed {
    logic sync_hold_mode;
    logic capture_input_choice;
    logic divider_reset_request;
  } timer_ctrl_type;

  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } pin_event_type;

endpackage : timer_prescale_pkg

// ### logic/pin_edge_sync.sv
// synchroniser and edge detector for one asynchronous input pin
// assumes rst_n is already synchronised to mclk
`timescale 1ns/100ps
module pin_edge_sync
  import timer_prescale_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic pin,
  output pin_event_type evt
);

  logic pin_lat;
  logic s1_q, s2_q, s3_q;
  logic s1_d, s2_d, s3_d;

  // transparent while the clock is high, so the first flop sees a settled level
  always_latch begin
    if (mclk) begin
      pin_lat = pin; // RULE_07
    end
  end

  always_comb begin
    s1_d = pin_lat;
    s2_d = s1_q;
    s3_d = s2_q;
  end

  always_ff @(posedge mclk or negedge rst_n) begin // RULE_06 RULE_07
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end

  // s1 feeds only s2; edges come from the two later stages
  always_comb begin
    evt.level = s3_q;
    evt.rise = s2_q & ~s3_q;
    evt.fall = ~s2_q & s3_q;
  end

endmodule : pin_edge_sync

// ### logic/shared_timer_prescaler.sv
// shared prescaler and clock select for two timer/counters, Avalon-MM slave
// assumes count and capture pins are asynchronous to mclk
//
// Function
// RULE_01 - clock select 1 ticks the timer every system clock cycle
// RULE_02 - divider offers taps at clock divided by 8, 64, 256, 1024
// RULE_03 - one free-running divider serves both timers, each selecting its own tap
// RULE_04 - first divided tick arrives 1 to N+1 cycles after enabling
// RULE_05 - divider reset restarts the divided period for every attached timer
// RULE_06 - external count pin sampled every cycle, then edge detected
// RULE_07 - synchroniser flops on rising edge, preceded by latch open while clock high
// RULE_08 - select 7 ticks per rising pin edge, select 6 per falling edge
// RULE_09 - counter update lands 2.5 to 3.5 cycles after the pin edge
// RULE_10 - software switches external source only while the pin is stable
// RULE_11 - external clock half periods exceed one cycle, frequency below clock/2.5
// RULE_12 - external ticks bypass the divider, never divided
// RULE_13 - while hold bit is one, divider reset request keeps its written value
// RULE_14 - writing hold bit zero clears the reset request so timers start together
// RULE_15 - writing reset request one resets divider, self-clears unless hold set
// RULE_16 - capture select bit picks pin A when zero, pin B when one
// RULE_17 - clock select zero delivers no ticks, timer stopped
// RULE_18 - select values 2 to 5 pick the /8, /64, /256, /1024 taps
//
// Decided for this implementation: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/100ps
module shared_timer_prescaler
  import timer_prescale_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [NUM_TIMERS-1:0] external_count_pin,
  input wire logic capture_pin_a,
  input wire logic capture_pin_b,
  output logic [NUM_TIMERS-1:0] timer_tick,
  output logic capture_trigger
);

  // reset release
  logic rst_meta_q, rst_n;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // pin synchronisers: count pins first, then capture pins A and B
  localparam int NUM_PINS = NUM_TIMERS + 2;
  logic [NUM_PINS-1:0] pins_raw;
  pin_event_type pin_evt [NUM_PINS];

  assign pins_raw = {capture_pin_b, capture_pin_a, external_count_pin};

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PINS; gp++) begin : g_pin
      pin_edge_sync u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .pin(pins_raw[gp]),
        .evt(pin_evt[gp])
      );
    end
  endgenerate

  // bus slave: one wait cycle, then the request is accepted
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic req, accept, wr_gtc, wr_csel;
  timer_ctrl_type ctrl_q, ctrl_d;
  clock_select_type csel_q [NUM_TIMERS];
  clock_select_type csel_d [NUM_TIMERS];
  logic [DIV_WIDTH-1:0] div_q, div_d;

  always_comb begin
    req = avs_read | avs_write;
    accept = req & ~wait_q;
    wr_gtc = accept & avs_write & avs_byteenable[0] & (avs_address == GTC_OFFSET);
    wr_csel = accept & avs_write & avs_byteenable[0] & (avs_address == CSEL_OFFSET);
    wait_d = ~(req & wait_q);
    rdata_d = rdata_q;
    if (req && wait_q && avs_read) begin
      unique case (avs_address)
        GTC_OFFSET: begin
          rdata_d = 32'h0000_0000;
          rdata_d[HOLD_BIT] = ctrl_q.sync_hold_mode;
          rdata_d[CAPSEL_BIT] = ctrl_q.capture_input_choice;
          rdata_d[PSR_BIT] = ctrl_q.divider_reset_request;
        end
        CSEL_OFFSET: begin
          rdata_d = 32'h0000_0000;
          rdata_d[CSEL_T0_LSB +: 3] = csel_q[0];
          rdata_d[CSEL_T1_LSB +: 3] = csel_q[1];
        end
        STATUS_OFFSET: begin
          rdata_d = {22'h000000, div_q};
        end
        default: begin
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;

  // control register and clock selects
  always_comb begin
    ctrl_d = ctrl_q;
    csel_d = csel_q;
    // request self-clears unless hold mode keeps it
    if (!ctrl_q.sync_hold_mode) begin
      ctrl_d.divider_reset_request = 1'b0; // RULE_15 RULE_14
    end
    if (wr_gtc) begin
      ctrl_d.sync_hold_mode = avs_writedata[HOLD_BIT];
      ctrl_d.capture_input_choice = avs_writedata[CAPSEL_BIT];
      ctrl_d.divider_reset_request = avs_writedata[PSR_BIT]; // RULE_13 RULE_15
    end
    if (wr_csel) begin
      csel_d[0] = clock_select_type'(avs_writedata[CSEL_T0_LSB +: 3]);
      csel_d[1] = clock_select_type'(avs_writedata[CSEL_T1_LSB +: 3]);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= timer_ctrl_type'({GTC_RESET[HOLD_BIT], GTC_RESET[CAPSEL_BIT], GTC_RESET[PSR_BIT]});
      csel_q[0] <= clock_select_type'(CSEL_RESET);
      csel_q[1] <= clock_select_type'(CSEL_RESET);
    end else begin
      ctrl_q <= ctrl_d;
      csel_q <= csel_d;
    end
  end

  // free-running divider, held at zero while the reset request stands
  always_comb begin
    div_d = div_q + 10'h001; // RULE_03
    if (ctrl_q.divider_reset_request) begin
      div_d = DIV_RESET; // RULE_05
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= DIV_RESET;
    end else begin
      div_q <= div_d;
    end
  end

  // a tap fires on the cycle its low bits are all ones and no reset request stands
  logic tap8, tap64, tap256, tap1024, taps_live;

  always_comb begin
    taps_live = ~ctrl_q.divider_reset_request;
    tap8 = taps_live & (&div_q[TAP8_BITS-1:0]); // RULE_02 RULE_04
    tap64 = taps_live & (&div_q[TAP64_BITS-1:0]);
    tap256 = taps_live & (&div_q[TAP256_BITS-1:0]);
    tap1024 = taps_live & (&div_q[TAP1024_BITS-1:0]);
  end

  // per-timer tick selection, registered so every tick is a clean one-cycle pulse
  logic [NUM_TIMERS-1:0] tick_q, tick_d;

  genvar gt;
  generate
    for (gt = 0; gt < NUM_TIMERS; gt++) begin : g_tick
      always_comb begin
        unique case (csel_q[gt])
          CS_STOP: tick_d[gt] = 1'b0; // RULE_17
          CS_DIRECT: tick_d[gt] = 1'b1; // RULE_01
          CS_DIV8: tick_d[gt] = tap8; // RULE_18
          CS_DIV64: tick_d[gt] = tap64;
          CS_DIV256: tick_d[gt] = tap256;
          CS_DIV1024: tick_d[gt] = tap1024;
          // pin edges skip the divider entirely
          CS_EXT_FALL: tick_d[gt] = pin_evt[gt].fall; // RULE_08 RULE_12 RULE_09
          CS_EXT_RISE: tick_d[gt] = pin_evt[gt].rise; // RULE_08 RULE_12
        endcase
      end
    end
  endgenerate

  logic cap_q, cap_d;

  always_comb begin
    cap_d = ctrl_q.capture_input_choice ? pin_evt[NUM_TIMERS+1].level : pin_evt[NUM_TIMERS].level; // RULE_16
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tick_q <= '0;
      cap_q <= 1'b0;
    end else begin
      tick_q <= tick_d;
      cap_q <= cap_d;
    end
  end

  assign timer_tick = tick_q;
  assign capture_trigger = cap_q;

  // checks
  a_direct_every_cycle: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_01
    (csel_q[0] == CS_DIRECT) [*2] |-> timer_tick[0])
    else $error("direct select missed a tick");

  a_stopped_no_tick: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_17
    (csel_q[1] == CS_STOP) [*2] |-> !timer_tick[1])
    else $error("stopped timer ticked");

  a_div8_period: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_02
    (csel_q[0] == CS_DIV8) [*2] ##0 timer_tick[0] |-> ##1 !timer_tick[0] [*7])
    else $error("divide by 8 tap ticked too early");

  a_divider_free_run: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_03
    !ctrl_q.divider_reset_request |=> div_q == $past(div_q) + 10'h001)
    else $error("divider did not advance");

  a_reset_restart: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_05
    ctrl_q.divider_reset_request |=> (div_q == DIV_RESET)
      && (!timer_tick[0] || $past(csel_q[0]) inside {CS_DIRECT, CS_EXT_FALL, CS_EXT_RISE})
      && (!timer_tick[1] || $past(csel_q[1]) inside {CS_DIRECT, CS_EXT_FALL, CS_EXT_RISE}))
    else $error("divider reset did not restart the period");

  a_hold_keeps_request: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_13
    (ctrl_q.sync_hold_mode && !wr_gtc) |=> $stable(ctrl_q.divider_reset_request))
    else $error("reset request changed in hold mode");

  a_request_self_clear: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_15
    (!ctrl_q.sync_hold_mode && !wr_gtc) |=> !ctrl_q.divider_reset_request)
    else $error("reset request not cleared");

  a_hold_release: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_14
    (wr_gtc && !avs_writedata[HOLD_BIT]) ##1 !wr_gtc |=> !ctrl_q.divider_reset_request)
    else $error("hold release left the request set");

  a_ext_rise_tick: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_08
    (csel_q[0] == CS_EXT_RISE && pin_evt[0].rise) |=> timer_tick[0])
    else $error("rising pin edge gave no tick");

  a_capture_route: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_16
    !ctrl_q.capture_input_choice |=> capture_trigger == $past(pin_evt[NUM_TIMERS].level))
    else $error("capture pin a not routed");

  a_capture_route_b: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_16
    ctrl_q.capture_input_choice |=> capture_trigger == $past(pin_evt[NUM_TIMERS+1].level))
    else $error("capture pin b not routed");

  a_stop_timer0: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_17
    $past(csel_q[0]) == CS_STOP |-> !timer_tick[0])
    else $error("stopped first timer ticked");

  a_direct_timer1: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_01
    $past(csel_q[1]) == CS_DIRECT |-> timer_tick[1])
    else $error("direct select missed a tick on second timer");

  a_tap64_phase: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_18
    (timer_tick[0] && $past(csel_q[0]) == CS_DIV64) |-> div_q[TAP64_BITS-1:0] == '0)
    else $error("divide by 64 tick off its tap");

  a_tap256_phase: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_02
    (timer_tick[1] && $past(csel_q[1]) == CS_DIV256) |-> div_q[TAP256_BITS-1:0] == '0)
    else $error("divide by 256 tick off its tap");

  a_tap1024_phase: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_18
    (timer_tick[0] && $past(csel_q[0]) == CS_DIV1024) |-> div_q[TAP1024_BITS-1:0] == '0)
    else $error("divide by 1024 tick off its tap");

  a_release_restart: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_14
    $fell(ctrl_q.divider_reset_request) |-> div_q == DIV_RESET)
    else $error("released divider did not start from zero");

  a_ext_fall_tick: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_08
    ($fell(pin_evt[1].level) && $past(csel_q[1]) == CS_EXT_FALL) |-> timer_tick[1])
    else $error("falling pin edge gave no tick");

  a_ext_rise_latency: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_09
    ($rose(pin_evt[0].level) && $past(csel_q[0]) == CS_EXT_RISE) |-> timer_tick[0])
    else $error("pin tick not aligned with the last synchroniser stage");

  a_ext_bypass: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_12
    ($past(csel_q[0]) == CS_EXT_RISE && !$past(pin_evt[0].rise)) |-> !timer_tick[0])
    else $error("pin source ticked without a pin edge");

endmodule : shared_timer_prescaler

// ### sim/tick_count_model.sv
// counts the ticks that each attached timer core would see
// assumes ticks are one-cycle qualifiers sampled on mclk
`timescale 1ns/100ps
module tick_count_model
  import timer_prescale_pkg::*;
(
  input wire logic mclk,
  input wire logic [NUM_TIMERS-1:0] timer_tick,
  output int cnt0,
  output int cnt1
);
  // a timer core advances once for every cycle its qualifier is high
  always_ff @(posedge mclk) begin
    cnt0 <= cnt0 + int'(timer_tick[0]);
    cnt1 <= cnt1 + int'(timer_tick[1]);
  end
endmodule : tick_count_model

// ### sim/tb.sv
// self-checking bench for the shared timer prescaler
// assumes one 40 MHz clock and a one-wait-cycle Avalon-MM slave
`timescale 1ns/100ps
module tb;
  import timer_prescale_pkg::*;
  logic mclk = 0, rst_b = 0, avs_read = 0, avs_write = 0, avs_waitrequest;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd, r;
  logic capture_pin_a = 0, capture_pin_b = 0, capture_trigger;
  logic [NUM_TIMERS-1:0] external_count_pin = '0, timer_tick;
  logic [31:0] seed = 32'h2f21bfc4;
  int cnt0, cnt1, s0, s1, d0, d1, fail_count = 0, n_checks = 0;
  int divs[6] = '{0, 1, 8, 64, 256, 1024};

  initial begin
    forever #12.5 mclk = ~mclk;
  end

  shared_timer_prescaler i_shared_timer_prescaler (.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .external_count_pin(external_count_pin),
    .capture_pin_a(capture_pin_a), .capture_pin_b(capture_pin_b), .timer_tick(timer_tick),
    .capture_trigger(capture_trigger));
  tick_count_model i_tick_count_model (.mclk(mclk), .timer_tick(timer_tick), .cnt0(cnt0), .cnt1(cnt1));

  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function int exp_ticks(input int cs, input int len);
    return (cs == 0) ? 0 : len / divs[cs];
  endfunction : exp_ticks

  task print_verdict();
    $display("checks=%0d failures=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  // entered just after a rising edge; request held until waitrequest is seen low
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    if (n >= 50) begin
      fail_count++;
      print_verdict();
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask : bus

  task window(input int len);
    s0 = cnt0;
    s1 = cnt1;
    cyc(len);
    d0 = cnt0 - s0;
    d1 = cnt1 - s1;
  endtask : window

  initial begin
    cyc(2);
    rst_b <= 1'b1;
    cyc(3);
    bus(0, CSEL_OFFSET, 32'h0, rd);
    check(rd, 32'h0);
    bus(1, 4'hc, 32'hff, rd);
    bus(0, 4'hc, 32'h0, rd);
    check(rd, 32'h0);
    bus(0, GTC_OFFSET, 32'h0, rd);
    check(rd, 32'h0);
    // both timers on different sources over a span every divisor fits
    for (int c = 0; c < 6; c++) begin
      bus(1, CSEL_OFFSET, 32'(c | (((c + 1) % 6) << 4)), rd);
      cyc(4);
      window(2048);
      check(d0, exp_ticks(c, 2048));
      check(d1, exp_ticks((c + 1) % 6, 2048));
    end
    bus(1, CSEL_OFFSET, 32'h23, rd);
    bus(1, GTC_OFFSET, 32'h81, rd);
    window(300);
    check(d0 + d1, 0);
    bus(0, GTC_OFFSET, 32'h0, rd);
    check(rd, 32'h81);
    bus(0, STATUS_OFFSET, 32'h0, rd);
    check(rd, 32'h0);
    // a window that is not a multiple of 64 exposes where the divider restarted
    bus(1, GTC_OFFSET, 32'h0, rd);
    window(60);
    check(d1, 7);
    check(d0, 0);
    bus(1, GTC_OFFSET, 32'h1, rd);
    window(60);
    check(d1, 7);
    check(d0, 0);
    bus(0, GTC_OFFSET, 32'h0, rd);
    check(rd, 32'h0);
    // pin held still across enabling; half periods of 2 to 5 cycles
    bus(1, CSEL_OFFSET, 32'h67, rd);
    cyc(4);
    s0 = cnt0;
    s1 = cnt1;
    for (int i = 0; i < 20; i++) begin
      external_count_pin <= ~external_count_pin;
      cyc(2 + int'(xs() % 4));
    end
    cyc(6);
    check(cnt0 - s0, 10);
    check(cnt1 - s1, 10);
    for (int c = 0; c < 2; c++) begin
      bus(1, GTC_OFFSET, 32'(c << 6), rd);
      for (int k = 0; k < 4; k++) begin
        r = xs();
        capture_pin_a <= r[0];
        capture_pin_b <= r[1];
        cyc(6);
        check(capture_trigger, c ? r[1] : r[0]);
      end
    end
    avs_byteenable <= 4'h0;
    bus(1, GTC_OFFSET, 32'h0, rd);
    avs_byteenable <= 4'hf;
    bus(0, GTC_OFFSET, 32'h0, rd);
    check(rd, 32'h40);
    print_verdict();
  end
endmodule : tb
